// ===== rtl/sar_adc_conversion_control.sv
/*
  Successive-approximation conversion control: trial-code sequencing,
  end-of-conversion flag, result latch and channel latch.
  Assumes all inputs are synchronous to mclk_in, one mclk period per
  converter clock, and an external comparator that reports whether the
  selected input lies below the reference built from trial_code_out.
*/
`timescale 1ns/100ps
module sar_adc_conversion_control
  import sar_adc_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                srst_in,
  input  wire logic                start_in,
  input  wire logic                cmp_below_in,
  input  wire logic                oe_in,
  input  wire chan_req_t           chan_req_in,
  output logic [CODE_W-1:0]        trial_code_out,
  output logic                     eoc_out,
  output logic [NUM_CHAN-1:0]      chan_sel_out,
  output result_pins_t             result_out
);

  conv_state_t       state_reg;
  conv_state_t       state_next;
  logic [CODE_W-1:0] trial_reg;
  logic [CODE_W-1:0] trial_next;
  logic [2:0]        bit_idx_reg;
  logic [2:0]        bit_idx_next;
  logic [2:0]        clk_cnt_reg;
  logic [2:0]        clk_cnt_next;
  logic              eoc_reg;
  logic              eoc_next;
  logic              start_prev_reg;
  logic              start_next;
  logic              start_rise;
  logic              start_fall;
  logic              capture;
  logic              busy;

  assign start_rise = start_in & ~start_prev_reg;
  assign start_fall = ~start_in & start_prev_reg;
  assign busy       = (state_reg == ST_COMPARE) ||
                      (state_reg == ST_DELAY)   ||
                      (state_reg == ST_LATCH);

  // start edge tracking
  always_comb begin
    start_next = start_in;
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_next;
    end
  end

  // conversion sequencer
  always_comb begin
    state_next   = state_reg;
    trial_next   = trial_reg;
    bit_idx_next = bit_idx_reg;
    clk_cnt_next = clk_cnt_reg;
    eoc_next     = eoc_reg;
    capture      = 1'b0;
    if (start_rise) begin
      state_next   = ST_ARMED;
      trial_next   = TRIAL_LOAD;
      bit_idx_next = MSB_IDX;
      clk_cnt_next = CNT_RESET;
      eoc_next     = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_ARMED: begin
          if (start_fall) begin
            state_next   = ST_COMPARE;
            clk_cnt_next = CNT_RESET;
          end
        end
        ST_COMPARE: begin
          clk_cnt_next = clk_cnt_reg + 3'h1;
          if (clk_cnt_reg == LAST_BIT_CNT) begin
            if (cmp_below_in) begin
              trial_next[bit_idx_reg] = 1'b0;
            end
            if (bit_idx_reg == 3'h0) begin
              state_next   = ST_DELAY;
              clk_cnt_next = CNT_RESET;
            end else begin
              trial_next[bit_idx_reg - 3'h1] = 1'b1;
              bit_idx_next = bit_idx_reg - 3'h1;
            end
          end
        end
        ST_DELAY: begin
          clk_cnt_next = clk_cnt_reg + 3'h1;
          if (clk_cnt_reg == DELAY_LAST_CNT) begin
            state_next = ST_LATCH;
          end
        end
        ST_LATCH: begin
          // flag rise may itself be the next start
          capture    = 1'b1;
          eoc_next   = 1'b1;
          state_next = ST_IDLE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_reg   <= ST_IDLE;
      trial_reg   <= CODE_RESET;
      bit_idx_reg <= MSB_IDX;
      clk_cnt_reg <= CNT_RESET;
      eoc_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      trial_reg   <= trial_next;
      bit_idx_reg <= bit_idx_next;
      clk_cnt_reg <= clk_cnt_next;
      eoc_reg     <= eoc_next;
    end
  end

  assign trial_code_out = trial_reg;
  assign eoc_out        = eoc_reg;

  result_output_port u_result (
    .mclk_in    (mclk_in),
    .srst_in    (srst_in),
    .capture_in (capture),
    .code_in    (trial_reg),
    .oe_in      (oe_in),
    .pins_out   (result_out)
  );

  chan_select_latch u_chan (
    .mclk_in      (mclk_in),
    .srst_in      (srst_in),
    .chan_req_in  (chan_req_in),
    .chan_sel_out (chan_sel_out)
  );

  // helper: clocks spent comparing, and clocks since the start fall
  // since_fall saturates so an idle device never wraps into a false match
  logic [6:0] conv_len_reg;
  logic [6:0] conv_len_next;
  logic [6:0] since_fall_reg;
  logic [6:0] since_fall_next;

  always_comb begin
    conv_len_next   = 7'h00;
    since_fall_next = since_fall_reg;
    if (state_reg == ST_COMPARE) begin
      conv_len_next = conv_len_reg + 7'h01;
    end
    if (start_rise) begin
      since_fall_next = 7'h00;
    end else if (state_reg == ST_ARMED && start_fall) begin
      since_fall_next = 7'h01;
    end else if (since_fall_reg != 7'h00 && since_fall_reg != 7'h7F) begin
      since_fall_next = since_fall_reg + 7'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      conv_len_reg   <= 7'h00;
      since_fall_reg <= 7'h00;
    end else begin
      conv_len_reg   <= conv_len_next;
      since_fall_reg <= since_fall_next;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence decide_s;
    state_reg == ST_COMPARE && clk_cnt_reg == LAST_BIT_CNT && !start_rise;
  endsequence

  sequence settle_s;
    (state_reg == ST_DELAY && !start_rise) ##1 !start_rise;
  endsequence

  trial_load_a: assert property (
    start_rise |=> trial_reg == TRIAL_LOAD && state_reg == ST_ARMED)
    else $error("trial code not loaded with top bit on start rise");

  compare_entry_a: assert property (
    $rose(state_reg == ST_COMPARE) |-> $past(start_fall))
    else $error("comparing began without start fall");

  bit_below_a: assert property (
    decide_s ##0 cmp_below_in |=> trial_reg < $past(trial_reg))
    else $error("tried bit not cleared on below decision");

  bit_above_a: assert property (
    decide_s ##0 !cmp_below_in ##0 bit_idx_reg != 3'h0
    |=> trial_reg > $past(trial_reg))
    else $error("tried bit not kept or next bit not set");

  msb_first_a: assert property (
    decide_s ##0 bit_idx_reg != 3'h0
    |=> bit_idx_reg == $past(bit_idx_reg) - 3'h1)
    else $error("bits not resolved top down");

  conv_length_a: assert property (
    $rose(state_reg == ST_DELAY) |-> $past(conv_len_reg) == CONV_LAST_CNT)
    else $error("conversion did not last 64 clocks");

  latch_flag_a: assert property (
    $rose(eoc_reg) |-> $past(state_reg) == ST_LATCH &&
                       result_out.code == $past(trial_reg))
    else $error("flag raised without latching the final code");

  flag_low_a: assert property (
    start_rise |=> !eoc_reg)
    else $error("flag not cleared by start");

  flag_rise_a: assert property (
    $rose(eoc_reg) |-> $past(state_reg) == ST_LATCH)
    else $error("flag rose outside completion");

  restart_a: assert property (
    start_rise && busy |=> state_reg == ST_ARMED && trial_reg == TRIAL_LOAD)
    else $error("conversion not restarted by new start");

  eoc_delay_a: assert property (
    settle_s |=> eoc_reg)
    else $error("flag not raised one delay plus one latch clock late");

  hold_prev_a: assert property (
    busy && state_reg != ST_LATCH |=> $stable(result_out.code))
    else $error("result changed during conversion");

  first_trial_a: assert property (
    $rose(state_reg == ST_COMPARE) |-> trial_reg == TRIAL_LOAD)
    else $error("first comparing cycle did not try the top bit alone");

  armed_wait_a: assert property (
    state_reg == ST_ARMED && !start_fall && !start_rise
    |=> state_reg == ST_ARMED && trial_reg == TRIAL_LOAD)
    else $error("conversion began while start still high");

  decide_once_a: assert property (
    state_reg == ST_COMPARE && clk_cnt_reg != LAST_BIT_CNT && !start_rise
    |=> $stable(trial_reg))
    else $error("trial code changed between decision clocks");

  last_bit_a: assert property (
    decide_s ##0 bit_idx_reg == 3'h0 |=> state_reg == ST_DELAY)
    else $error("comparing did not end after the bottom bit");

  flag_hold_a: assert property (
    eoc_reg && !start_rise |=> eoc_reg)
    else $error("flag fell without a start pulse");

  conv_time_a: assert property (
    $rose(eoc_reg) |-> $past(since_fall_reg) ==
                       7'(CONV_CLKS + EOC_DELAY_CLKS + LATCH_CLKS))
    else $error("start fall to flag time wrong");

endmodule

// ===== rtl/sar_adc_pkg.sv
/*
  Shared constants, state codes and carrier structs for the 8-bit
  successive-approximation converter control.
  Assumes a single clock domain and synchronous active-high reset.
*/
package sar_adc_pkg;

  // code and channel geometry
  localparam int          CODE_W          = 8;
  localparam int          CHAN_W          = 3;
  localparam int          NUM_CHAN        = 8;

  // conversion timing in clocks
  localparam int          CLKS_PER_BIT    = 8;
  localparam int          CONV_CLKS       = CODE_W * CLKS_PER_BIT;
  localparam int          EOC_DELAY_CLKS  = 1;
  localparam int          LATCH_CLKS      = 1;

  // field positions and derived counts
  localparam logic [2:0]  MSB_IDX         = 3'(CODE_W - 1);
  localparam logic [2:0]  LAST_BIT_CNT    = 3'(CLKS_PER_BIT - 1);
  localparam logic [2:0]  DELAY_LAST_CNT  = 3'(EOC_DELAY_CLKS - 1);
  localparam logic [6:0]  CONV_LAST_CNT   = 7'(CONV_CLKS - 1);

  // reset and load values
  localparam logic [7:0]  TRIAL_LOAD      = 8'h80;
  localparam logic [7:0]  CODE_RESET      = 8'h00;
  localparam logic [2:0]  CHAN_RESET      = 3'h0;
  localparam logic [2:0]  CNT_RESET       = 3'h0;

  // gray codes along idle, armed, compare, delay, latch
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARMED   = 3'b001,
    ST_COMPARE = 3'b011,
    ST_DELAY   = 3'b010,
    ST_LATCH   = 3'b110
  } conv_state_t;

  typedef struct packed {
    logic              strobe;
    logic [CHAN_W-1:0] addr;
  } chan_req_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              oe;
  } result_pins_t;

endpackage

// ===== rtl/chan_select_latch.sv
/*
  Channel address latch and one-hot analog input selector.
  Assumes strobe and address are synchronous to mclk_in.
*/
`timescale 1ns/100ps
module chan_select_latch
  import sar_adc_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                srst_in,
  input  wire chan_req_t           chan_req_in,
  output logic [NUM_CHAN-1:0]      chan_sel_out
);

  logic                strobe_prev_reg;
  logic [CHAN_W-1:0]   chan_reg;
  logic [CHAN_W-1:0]   chan_next;
  logic [NUM_CHAN-1:0] sel_reg;
  logic [NUM_CHAN-1:0] sel_next;
  logic                strobe_rise;

  assign strobe_rise = chan_req_in.strobe & ~strobe_prev_reg;

  always_comb begin
    chan_next = chan_reg;
    if (strobe_rise) begin
      chan_next = chan_req_in.addr;
    end
  end

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_sel
    assign sel_next[i] = (chan_next == CHAN_W'(i));
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      strobe_prev_reg <= 1'b0;
      chan_reg        <= CHAN_RESET;
      sel_reg         <= NUM_CHAN'(1);
    end else begin
      strobe_prev_reg <= chan_req_in.strobe;
      chan_reg        <= chan_next;
      sel_reg         <= sel_next;
    end
  end

  assign chan_sel_out = sel_reg;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  chan_hold_a: assert property (
    !strobe_rise |=> $stable(chan_reg))
    else $error("channel changed without strobe rise");

  chan_onehot_a: assert property (
    strobe_rise |=> sel_reg == (NUM_CHAN'(1) << $past(chan_req_in.addr)))
    else $error("channel select does not match latched address");

endmodule

// ===== rtl/result_output_port.sv
/*
  Result latch and output-enable stage for the converted code.
  Assumes capture is a one-cycle pulse from the conversion control.
*/
`timescale 1ns/100ps
module result_output_port
  import sar_adc_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                srst_in,
  input  wire logic                capture_in,
  input  wire logic [CODE_W-1:0]   code_in,
  input  wire logic                oe_in,
  output result_pins_t             pins_out
);

  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] code_next;
  logic              oe_reg;
  logic              oe_next;

  always_comb begin
    code_next = code_reg;
    if (capture_in) begin
      code_next = code_in;
    end
    oe_next = oe_in;
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      code_reg <= CODE_RESET;
      oe_reg   <= 1'b0;
    end else begin
      code_reg <= code_next;
      oe_reg   <= oe_next;
    end
  end

  // bit 7 is the one-half pin
  assign pins_out = '{code: code_reg, oe: oe_reg};

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  result_hold_a: assert property (
    !capture_in |=> $stable(code_reg))
    else $error("result latch changed outside capture");

  pins_float_a: assert property (
    !oe_in |=> !pins_out.oe)
    else $error("result pins driven while enable low");

  pins_show_a: assert property (
    capture_in ##1 oe_in
    |=> pins_out.oe && pins_out.code == $past(code_in, 2))
    else $error("latched code not presented on pins");

endmodule

// ===== verif/cmp_model.sv
/*
  Behavioural comparator and analog front end facing the conversion control.
  Assumes each channel level is an ideal code and the reference sits half
  a step below the trial code.
*/
`timescale 1ns/100ps
module cmp_model
  import sar_adc_pkg::*;
(
  input  wire logic [CODE_W-1:0]               trial_in,
  input  wire logic [NUM_CHAN-1:0]             sel_in,
  input  wire logic [NUM_CHAN-1:0][CODE_W-1:0] lvl_in,
  output logic                                 below_out
);
  always_comb begin
    below_out = 1'b1;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (sel_in[i]) begin
        below_out = lvl_in[i] < trial_in;
      end
    end
  end
endmodule

// ===== verif/sar_adc_conversion_control_tb.sv
/*
  Self-checking bench for the conversion control with a comparator model.
  Assumes the package constants and the registered outputs of the notes.
*/
`timescale 1ns/100ps
module sar_adc_conversion_control_tb;
  import sar_adc_pkg::*;
  logic                               mclk_in;
  logic                               srst_in;
  logic                               start_drv;
  logic                               loop_en;
  logic                               start_w;
  logic                               oe_in;
  logic                               cmp_below;
  chan_req_t                          chan_req;
  logic [NUM_CHAN-1:0][CODE_W-1:0]    lvl;
  logic [CODE_W-1:0]                  trial_code;
  logic                               eoc;
  logic [NUM_CHAN-1:0]                chan_sel;
  result_pins_t                       result;
  logic [CODE_W-1:0]                  last_code;
  int                                 num_errors;
  int                                 n_compared;
  // one armed clock sits between the start rise and the start fall
  localparam int RUN_CLKS = CONV_CLKS + EOC_DELAY_CLKS + LATCH_CLKS + 1;

  // loopback feeds the flag straight back to start
  assign start_w = loop_en ? eoc : start_drv;

  sar_adc_conversion_control uut (
    .mclk_in        (mclk_in),
    .srst_in        (srst_in),
    .start_in       (start_w),
    .cmp_below_in   (cmp_below),
    .oe_in          (oe_in),
    .chan_req_in    (chan_req),
    .trial_code_out (trial_code),
    .eoc_out        (eoc),
    .chan_sel_out   (chan_sel),
    .result_out     (result)
  );

  cmp_model far_end (
    .trial_in  (trial_code),
    .sel_in    (chan_sel),
    .lvl_in    (lvl),
    .below_out (cmp_below)
  );

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic set_chan(input int ch);
    @(posedge mclk_in);
    chan_req <= '{strobe: 1'b1, addr: 3'(ch)};
    @(posedge mclk_in);
    chan_req <= '{strobe: 1'b0, addr: ~3'(ch)};
  endtask

  task automatic chan_test();
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      set_chan(ch);
      #1;
      chk("chan_sel", 9'(1 << ch), 9'(chan_sel));
      @(posedge mclk_in);
      #1;
      chk("chan_sel held", 9'(1 << ch), 9'(chan_sel));
    end
  endtask

  task automatic run_conv(input int ch, input int hold);
    int n;
    n = 0;
    set_chan(ch);
    @(posedge mclk_in);
    start_drv <= 1'b1;
    for (int i = 1; i <= hold; i++) begin
      @(posedge mclk_in);
      if (i == hold) begin
        start_drv <= 1'b0;
      end
      #1;
      chk("trial load", 9'h080, 9'(trial_code));
      chk("eoc low", 9'h000, 9'(eoc));
    end
    while (eoc !== 1'b1 && n < 200) begin
      @(posedge mclk_in);
      #1;
      n++;
      if (eoc !== 1'b1) begin
        chk("code held", 9'(last_code), 9'(result.code));
      end
    end
    chk("conv clocks", 9'(RUN_CLKS), 9'(n));
    chk("code", 9'(lvl[ch]), 9'(result.code));
    last_code = lvl[ch];
  endtask

  task automatic abort_conv(input int ch);
    set_chan(ch);
    @(posedge mclk_in);
    start_drv <= 1'b1;
    @(posedge mclk_in);
    start_drv <= 1'b0;
    repeat (30) @(posedge mclk_in);
    #1;
    chk("abort eoc", 9'h000, 9'(eoc));
    chk("abort hold", 9'(last_code), 9'(result.code));
  endtask

  task automatic oe_test();
    @(posedge mclk_in);
    oe_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk("pins on", {last_code, 1'b1}, result);
    run_conv(5, 1);
    @(posedge mclk_in);
    #1;
    chk("pins new", {lvl[5], 1'b1}, result);
    @(posedge mclk_in);
    oe_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    chk("pins off", 9'h000, 9'(result.oe));
  endtask

  task automatic loop_conv(input int ch);
    int n [3];
    set_chan(ch);
    @(posedge mclk_in);
    loop_en <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      n[r] = 0;
      do begin
        @(posedge mclk_in);
        #1;
        n[r]++;
      end while (eoc !== 1'b0 && n[r] < 200);
      do begin
        @(posedge mclk_in);
        #1;
        n[r]++;
      end while (eoc !== 1'b1 && n[r] < 400);
      chk("loop code", 9'(lvl[ch]), 9'(result.code));
    end
    chk("loop period", 9'(n[1]), 9'(n[2]));
    chk("loop length", 9'(RUN_CLKS + 1), 9'(n[1]));
    chk("loop fast", 9'h001, 9'(n[1] <= RUN_CLKS + 8));
    @(posedge mclk_in);
    loop_en <= 1'b0;
    repeat (RUN_CLKS + 8) @(posedge mclk_in);
    last_code = lvl[ch];
  endtask

  initial begin
    num_errors = 0;
    n_compared = 0;
    last_code = CODE_RESET;
    srst_in = 1'b1;
    start_drv = 1'b0;
    loop_en = 1'b0;
    oe_in = 1'b0;
    chan_req = '0;
    lvl = {8'hC3, 8'h7F, 8'h80, 8'h01, 8'h5A, 8'hA5, 8'hFF, 8'h00};
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    chk("reset eoc", 9'h000, 9'(eoc));
    chk("reset result", 9'h000, result);
    chan_test();
    run_conv(2, 1);
    run_conv(0, 1);
    run_conv(3, 3);
    run_conv(1, 1);
    abort_conv(5);
    run_conv(6, 1);
    oe_test();
    loop_conv(7);
    run_conv(4, 1);
    test_done();
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    num_errors++;
    test_done();
  end
endmodule
